/* cpw_params.svh */
`ifndef CPW_PARAMS_SVH
`define CPW_PARAMS_SVH

// ==========================================
// Register indices (byte address is four times the index)
`define CPW_IDX_CTRL_B 14'h0fb4
`define CPW_IDX_CTRL_A 14'h0fba
`define CPW_IDX_FLAGS 14'h0fc0
`define CPW_SUB_CTRL 14'h0000
`define CPW_SUB_LOW 14'h0001
`define CPW_SUB_HIGH 14'h0002
`define CPW_SUB_PER 14'h0003
`define CPW_SUB_STEER 14'h0004
`define CPW_SUB_COUNT 14'h0005

// ==========================================
// Control field positions
`define CPW_CFG_MSB 7
`define CPW_CFG_LSB 6
`define CPW_DCB_MSB 5
`define CPW_DCB_LSB 4
`define CPW_MODE_MSB 3
`define CPW_MODE_LSB 0
`define CPW_PWM_MSB 3
`define CPW_PWM_LSB 2
`define CPW_POL_AC 1
`define CPW_POL_BD 0

// ==========================================
// Mode codes
`define CPW_MODE_OFF 4'h0
`define CPW_MODE_RSVD 4'h1
`define CPW_MODE_TOGGLE 4'h2
`define CPW_MODE_CAP 4'h3
`define CPW_MODE_CAP_F 4'h4
`define CPW_MODE_CAP_R 4'h5
`define CPW_MODE_CAP_R4 4'h6
`define CPW_MODE_CAP_R16 4'h7
`define CPW_MODE_CMP_SET 4'h8
`define CPW_MODE_CMP_CLR 4'h9
`define CPW_MODE_CMP_SW 4'ha
`define CPW_MODE_CMP_TRIG 4'hb
`define CPW_PWM_SEL 2'h3

// ==========================================
// Counts and reset values
`define CPW_PRE4_LAST 4'h3
`define CPW_PRE16_LAST 4'hf
`define CPW_FINE_LAST 2'h3
`define CPW_CTRL_RST 8'h00
`define CPW_PER_RST 8'hff
`define CPW_STEER_RST 4'h1
`define CPW_RESP_OKAY 2'h0
`define CPW_RESP_SLVERR 2'h2

`endif

/* cpw_pkg.sv */
`default_nettype none
package cpw_pkg;
	typedef enum logic [1:0] {
		CPW_CFG_SINGLE,
		CPW_CFG_FWD,
		CPW_CFG_HALF,
		CPW_CFG_REV
	} cpw_cfg_e;
	typedef logic [3:0] cpw_mode_t;
endpackage
`default_nettype wire

/* cpw_unit_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cpw_unit_if;
	logic [7:0] ctrl;
	logic [7:0] period;
	logic [3:0] steer;
	logic [7:0] wdata;
	logic wr_lo;
	logic wr_hi;
	logic [15:0] timer;
	logic pin;
	logic [15:0] value;
	logic flag_set;
	logic [3:0] pins;
	logic [3:0] pins_oe_n;
	logic trig;
	modport ctl (
		output ctrl, period, steer, wdata, wr_lo, wr_hi, timer, pin,
		input value, flag_set, pins, pins_oe_n, trig
	);
	modport unit (
		input ctrl, period, steer, wdata, wr_lo, wr_hi, timer, pin,
		output value, flag_set, pins, pins_oe_n, trig
	);
endinterface
`default_nettype wire

/* cpw_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpw_params.svh"
module cpw_unit (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control and pins
	cpw_unit_if.unit u
);
	cpw_pkg::cpw_mode_t mode;
	cpw_pkg::cpw_cfg_e cfg;
	logic is_off, is_cap, is_pwm, is_cmp, rise, fall, cap_ev, cmp_ev, wrap;
	logic [3:0] lvl, drv, inv;
	logic [15:0] val_r, val_nxt;
	logic [1:0] dlsb_r, dlsb_nxt;
	logic [3:0] pre_r, pre_nxt;
	logic pin_d_r, match_d_r, match;
	logic [3:0] mode_d_r;
	logic cmp_r, cmp_nxt;
	logic [9:0] cnt_r, cnt_nxt;
	logic flag_r, flag_nxt, trig_r, trig_nxt;
	logic [3:0] out_r, out_nxt, oe_n_r, oe_n_nxt;

	// ==========================================
	// Next state
	always_comb begin
		mode = cpw_pkg::cpw_mode_t'(u.ctrl[`CPW_MODE_MSB:`CPW_MODE_LSB]);
		cfg = cpw_pkg::cpw_cfg_e'(u.ctrl[`CPW_CFG_MSB:`CPW_CFG_LSB]);
		is_off = (mode == `CPW_MODE_OFF) || (mode == `CPW_MODE_RSVD);
		is_cap = (mode >= `CPW_MODE_CAP) && (mode <= `CPW_MODE_CAP_R16);
		is_pwm = mode[`CPW_PWM_MSB:`CPW_PWM_LSB] == `CPW_PWM_SEL;
		is_cmp = !is_off && !is_cap && !is_pwm;
		rise = u.pin && !pin_d_r;
		fall = !u.pin && pin_d_r;
		// Prescaler counts rising edges, held clear outside capture
		pre_nxt = !is_cap ? 4'h0 : (rise ? pre_r + 4'h1 : pre_r);
		unique case (mode)
			`CPW_MODE_CAP, `CPW_MODE_CAP_F: cap_ev = fall;
			`CPW_MODE_CAP_R: cap_ev = rise;
			`CPW_MODE_CAP_R4: cap_ev = rise && (pre_r[1:0] == `CPW_FINE_LAST);
			`CPW_MODE_CAP_R16: cap_ev = rise && (pre_r == `CPW_PRE16_LAST);
			default: cap_ev = 1'b0;
		endcase
		match = u.timer == val_r;
		cmp_ev = is_cmp && match && !match_d_r;
		// PWM time base: 8-bit period count with two fine bits
		wrap = (cnt_r[9:2] == u.period) && (cnt_r[1:0] == `CPW_FINE_LAST);
		cnt_nxt = (!is_pwm || wrap) ? 10'h000 : cnt_r + 10'h001;
		dlsb_nxt = (is_pwm && wrap) ? u.ctrl[`CPW_DCB_MSB:`CPW_DCB_LSB] : dlsb_r;
		val_nxt = val_r;
		if (u.wr_lo) begin
			val_nxt[7:0] = u.wdata;
		end
		if (u.wr_hi && !is_pwm) begin
			val_nxt[15:8] = u.wdata;
		end
		if (cap_ev) begin
			val_nxt = u.timer;
		end
		if (is_pwm && wrap) begin
			val_nxt[15:8] = val_r[7:0];
		end
		// Compare output latch
		cmp_nxt = cmp_r;
		if (is_off) begin
			cmp_nxt = 1'b0;
		end else if (mode != mode_d_r) begin
			if (mode == `CPW_MODE_CMP_SET) begin
				cmp_nxt = 1'b0;
			end else if (mode == `CPW_MODE_CMP_CLR) begin
				cmp_nxt = 1'b1;
			end
		end else if (cmp_ev) begin
			unique case (mode)
				`CPW_MODE_TOGGLE: cmp_nxt = !cmp_r;
				`CPW_MODE_CMP_SET: cmp_nxt = 1'b1;
				`CPW_MODE_CMP_CLR: cmp_nxt = 1'b0;
				default: cmp_nxt = cmp_r;
			endcase
		end
		flag_nxt = cap_ev || (cmp_ev && mode != mode_d_r ? 1'b0 : cmp_ev);
		trig_nxt = cmp_ev && (mode == `CPW_MODE_CMP_TRIG) && (mode == mode_d_r);
		// Output steering; pins ordered d, c, b, a
		lvl = 4'h0;
		drv = 4'h0;
		inv = {u.ctrl[`CPW_POL_BD], u.ctrl[`CPW_POL_AC], u.ctrl[`CPW_POL_BD], u.ctrl[`CPW_POL_AC]};
		if (is_pwm) begin
			unique case (cfg)
				cpw_pkg::CPW_CFG_SINGLE: begin
					lvl = {4{cnt_nxt < {val_nxt[15:8], dlsb_nxt}}};
					drv = u.steer;
				end
				cpw_pkg::CPW_CFG_FWD: begin
					lvl = {cnt_nxt < {val_nxt[15:8], dlsb_nxt}, 2'b00, 1'b1};
					drv = 4'hf;
				end
				cpw_pkg::CPW_CFG_HALF: begin
					lvl = {2'b00, !(cnt_nxt < {val_nxt[15:8], dlsb_nxt}),
						cnt_nxt < {val_nxt[15:8], dlsb_nxt}};
					drv = 4'h3;
				end
				cpw_pkg::CPW_CFG_REV: begin
					lvl = {2'b01, cnt_nxt < {val_nxt[15:8], dlsb_nxt}, 1'b0};
					drv = 4'hf;
				end
			endcase
			out_nxt = (lvl ^ inv) & drv;
		end else begin
			inv = 4'h0;
			if ((mode == `CPW_MODE_TOGGLE) || (mode == `CPW_MODE_CMP_SET)
				|| (mode == `CPW_MODE_CMP_CLR)) begin
				drv = 4'h1;
			end
			out_nxt = {3'b000, cmp_nxt & drv[0]};
		end
		oe_n_nxt = ~drv;
		if (is_off) begin
			pre_nxt = 4'h0;
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			val_r <= 16'h0000;
			dlsb_r <= 2'h0;
			pre_r <= 4'h0;
			pin_d_r <= 1'b0;
			match_d_r <= 1'b0;
			mode_d_r <= `CPW_MODE_OFF;
			cmp_r <= 1'b0;
			cnt_r <= 10'h000;
			flag_r <= 1'b0;
			trig_r <= 1'b0;
			out_r <= 4'h0;
			oe_n_r <= 4'hf;
		end else begin
			val_r <= val_nxt;
			dlsb_r <= dlsb_nxt;
			pre_r <= pre_nxt;
			pin_d_r <= u.pin;
			match_d_r <= match;
			mode_d_r <= mode;
			cmp_r <= cmp_nxt;
			cnt_r <= cnt_nxt;
			flag_r <= flag_nxt;
			trig_r <= trig_nxt;
			out_r <= out_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign u.value = val_r;
	assign u.flag_set = flag_r;
	assign u.trig = trig_r;
	assign u.pins = out_r;
	assign u.pins_oe_n = oe_n_r;
endmodule
`default_nettype wire

/* cpw_top.sv */
// Function
// - two units, each with 16-bit value register
// - non-PWM modes: B-D released, A driven in 0010, 1000, 1001 only
// - PWM single output: steering picks driven pins
// - Full-bridge forward: D modulated, A active
// - Half-bridge: A, B modulated, C, D released
// - Full-bridge reverse: B modulated, C active
// - Two duty-low bits extend duty to ten
// - Mode zero turns unit off, resets it
// - Mode 0010 toggles pin on compare match
// - Capture on falling, rising, 4th, 16th edge
// - Mode 1000: start low, set on match
// - Mode 1001: start high, clear on match
// - Mode 1010: flag only, pin released
// - Mode 1011: timer reset, conversion start, flag
// - Modes 11xx select PWM with polarity
// - Up to four PWM outputs A-D
// - Capture sets sticky flag, overwrites old value
// - Prescaler cleared when off or not capturing
// - Period match restarts timer, sets output, latches duty
// - Duty written anytime, applied at period end
`timescale 1ns/1ps
`default_nettype none
`include "cpw_params.svh"
module cpw_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [15:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [15:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer counts
	input wire logic [15:0] timer_one_count,
	input wire logic [15:0] timer_three_count,
	// Event pins
	input wire logic unit_pin_a_in,
	input wire logic unit_pin_b_in,
	// Unit A outputs, bit order d, c, b, a
	output logic [3:0] unit_a_out,
	output logic [3:0] unit_a_oe_n,
	output logic unit_a_timer_rst,
	output logic unit_a_adc_start,
	// Unit B outputs, bit order d, c, b, a
	output logic [3:0] unit_b_out,
	output logic [3:0] unit_b_oe_n,
	output logic unit_b_timer_rst,
	output logic unit_b_adc_start
);
	// ==========================================
	// Declarations
	cpw_unit_if ui[2] ();
	logic [7:0] ctrl_r[2], ctrl_nxt[2];
	logic [7:0] per_r[2], per_nxt[2];
	logic [3:0] steer_r[2], steer_nxt[2];
	logic [1:0] flags_r, flags_nxt;
	logic [1:0] sync1_r, sync2_r;
	logic [15:0] val_w[2];
	logic [1:0] flag_set_w;
	logic [13:0] base_w[2];
	logic [15:0] awaddr_r, awaddr_nxt;
	logic [7:0] wbyte_r, wbyte_nxt;
	logic wstrb0_r, wstrb0_nxt;
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_wr, ar_take;
	logic [13:0] widx, ridx, wsub, rsub;
	logic [1:0] wr_lo, wr_hi;
	logic wr_hit, rd_hit;

	assign base_w[0] = `CPW_IDX_CTRL_A;
	assign base_w[1] = `CPW_IDX_CTRL_B;

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end else begin
			sync1_r <= {unit_pin_b_in, unit_pin_a_in};
			sync2_r <= sync1_r;
		end
	end

	// ==========================================
	// Units
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_unit
			assign ui[gi].ctrl = ctrl_r[gi];
			assign ui[gi].period = per_r[gi];
			assign ui[gi].steer = steer_r[gi];
			assign ui[gi].wdata = wbyte_r;
			assign ui[gi].wr_lo = wr_lo[gi];
			assign ui[gi].wr_hi = wr_hi[gi];
			assign ui[gi].timer = (gi == 0) ? timer_one_count : timer_three_count;
			assign ui[gi].pin = sync2_r[gi];
			assign val_w[gi] = ui[gi].value;
			assign flag_set_w[gi] = ui[gi].flag_set;
			cpw_unit u_unit (
				.aclk(aclk),
				.aresetn(aresetn),
				.u(ui[gi].unit)
			);
		end
	endgenerate

	assign unit_a_out = ui[0].pins;
	assign unit_a_oe_n = ui[0].pins_oe_n;
	assign unit_a_timer_rst = ui[0].trig;
	assign unit_a_adc_start = ui[0].trig;
	assign unit_b_out = ui[1].pins;
	assign unit_b_oe_n = ui[1].pins_oe_n;
	assign unit_b_timer_rst = ui[1].trig;
	assign unit_b_adc_start = ui[1].trig;

	// ==========================================
	// Bus and register next state
	always_comb begin
		do_wr = aw_have_r && w_have_r && !bvalid_r;
		ar_take = s_axi_arvalid && arready_r;
		widx = awaddr_r[15:2];
		ridx = s_axi_araddr[15:2];
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		wr_lo = 2'h0;
		wr_hi = 2'h0;
		rdata_nxt = rdata_r;
		for (int i = 0; i < 2; i++) begin
			ctrl_nxt[i] = ctrl_r[i];
			per_nxt[i] = per_r[i];
			steer_nxt[i] = steer_r[i];
		end
		// Write address and data are taken independently
		aw_have_nxt = aw_have_r || (s_axi_awvalid && awready_r);
		w_have_nxt = w_have_r || (s_axi_wvalid && wready_r);
		awaddr_nxt = (s_axi_awvalid && awready_r) ? s_axi_awaddr : awaddr_r;
		wbyte_nxt = (s_axi_wvalid && wready_r) ? s_axi_wdata[7:0] : wbyte_r;
		wstrb0_nxt = (s_axi_wvalid && wready_r) ? s_axi_wstrb[0] : wstrb0_r;
		flags_nxt = flags_r;
		bvalid_nxt = bvalid_r && !s_axi_bready;
		bresp_nxt = bresp_r;
		for (int i = 0; i < 2; i++) begin
			wsub = 14'(widx - base_w[i]);
			if (wsub < `CPW_SUB_COUNT) begin
				wr_hit = 1'b1;
				if (do_wr && wstrb0_r) begin
					unique case (wsub)
						`CPW_SUB_CTRL: ctrl_nxt[i] = wbyte_r;
						`CPW_SUB_LOW: wr_lo[i] = 1'b1;
						`CPW_SUB_HIGH: wr_hi[i] = 1'b1;
						`CPW_SUB_PER: per_nxt[i] = wbyte_r;
						`CPW_SUB_STEER: steer_nxt[i] = wbyte_r[3:0];
						default: ctrl_nxt[i] = ctrl_r[i];
					endcase
				end
			end
		end
		if (widx == `CPW_IDX_FLAGS) begin
			wr_hit = 1'b1;
			if (do_wr && wstrb0_r) begin
				flags_nxt = flags_r & ~wbyte_r[1:0];
			end
		end
		// A new event wins over a clear in the same cycle
		flags_nxt = flags_nxt | flag_set_w;
		if (do_wr) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? `CPW_RESP_OKAY : `CPW_RESP_SLVERR;
		end
		awready_nxt = !aw_have_nxt && !bvalid_nxt && !do_wr;
		wready_nxt = !w_have_nxt && !bvalid_nxt && !do_wr;
		// Read path answers one cycle after the address is taken
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rresp_nxt = rresp_r;
		if (ar_take) begin
			rdata_nxt = 32'h0000_0000;
			for (int i = 0; i < 2; i++) begin
				rsub = 14'(ridx - base_w[i]);
				if (rsub < `CPW_SUB_COUNT) begin
					rd_hit = 1'b1;
					unique case (rsub)
						`CPW_SUB_CTRL: rdata_nxt[7:0] = ctrl_r[i];
						`CPW_SUB_LOW: rdata_nxt[7:0] = val_w[i][7:0];
						`CPW_SUB_HIGH: rdata_nxt[7:0] = val_w[i][15:8];
						`CPW_SUB_PER: rdata_nxt[7:0] = per_r[i];
						`CPW_SUB_STEER: rdata_nxt[3:0] = steer_r[i];
						default: rdata_nxt[7:0] = 8'h00;
					endcase
				end
			end
			if (ridx == `CPW_IDX_FLAGS) begin
				rd_hit = 1'b1;
				rdata_nxt[1:0] = flags_r;
			end
			rvalid_nxt = 1'b1;
			rresp_nxt = rd_hit ? `CPW_RESP_OKAY : `CPW_RESP_SLVERR;
		end
		arready_nxt = !rvalid_nxt;
	end

	// ==========================================
	// Bus and register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 2; i++) begin
				ctrl_r[i] <= `CPW_CTRL_RST;
				per_r[i] <= `CPW_PER_RST;
				steer_r[i] <= `CPW_STEER_RST;
			end
			flags_r <= 2'h0;
			awaddr_r <= 16'h0000;
			wbyte_r <= 8'h00;
			wstrb0_r <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `CPW_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= `CPW_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 2; i++) begin
				ctrl_r[i] <= ctrl_nxt[i];
				per_r[i] <= per_nxt[i];
				steer_r[i] <= steer_nxt[i];
			end
			flags_r <= flags_nxt;
			awaddr_r <= awaddr_nxt;
			wbyte_r <= wbyte_nxt;
			wstrb0_r <= wstrb0_nxt;
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
endmodule
`default_nettype wire

/* cpw_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpw_far_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench control
	input wire logic run,
	input wire logic clr,
	// Timer resets from the units
	input wire logic rst_a,
	input wire logic rst_b,
	// Time bases
	output logic [15:0] count_a,
	output logic [15:0] count_b
);
	// ==========
	// Time bases
	logic [15:0] count_a_r, count_a_nxt, count_b_r, count_b_nxt;
	always_comb begin
		count_a_nxt = count_a_r + (run ? 16'h0001 : 16'h0000);
		count_b_nxt = count_b_r + (run ? 16'h0001 : 16'h0000);
		if (clr || rst_a) count_a_nxt = 16'h0000;
		if (clr || rst_b) count_b_nxt = 16'h0000;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_a_r <= 16'h0000;
			count_b_r <= 16'h0000;
		end else begin
			count_a_r <= count_a_nxt;
			count_b_r <= count_b_nxt;
		end
	end
	assign count_a = count_a_r;
	assign count_b = count_b_r;
endmodule
`default_nettype wire

/* cpw_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cpw_top_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Unit A outputs
	input wire logic [3:0] unit_a_out,
	input wire logic [3:0] unit_a_oe_n,
	input wire logic unit_a_timer_rst,
	input wire logic unit_a_adc_start
);
	// ==========
	// Properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_reset_off: assert property ($rose(aresetn) |-> unit_a_oe_n == 4'hf && unit_a_out == 4'h0)
		else $error("unit not off after reset");
	a_trig_pair: assert property (unit_a_timer_rst == unit_a_adc_start)
		else $error("timer reset and conversion start differ");
	a_trig_pulse: assert property (unit_a_timer_rst |=> !unit_a_timer_rst)
		else $error("trigger longer than one cycle");
	a_trig_pins_free: assert property (unit_a_timer_rst |-> unit_a_oe_n == 4'hf)
		else $error("pins driven in trigger mode");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	c_trigger: cover property (unit_a_timer_rst);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_pwm_edge: cover property ($rose(unit_a_out[3]));
endmodule
bind cpw_top cpw_top_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .unit_a_out, .unit_a_oe_n, .unit_a_timer_rst,
	.unit_a_adc_start);
`default_nettype wire

/* test_capture_compare_pwm_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpw_params.svh"
module test_capture_compare_pwm_control;
	localparam logic [13:0] CA = `CPW_IDX_CTRL_A;
	localparam logic [13:0] CB = `CPW_IDX_CTRL_B;
	localparam logic [13:0] FL = `CPW_IDX_FLAGS;
	logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, clr = 1'h0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, unit_pin_a_in = 1'h0, unit_pin_b_in = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, p0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [15:0] timer_one_count, timer_three_count;
	logic [3:0] unit_a_out, unit_a_oe_n, unit_b_out, unit_b_oe_n;
	logic unit_a_timer_rst, unit_a_adc_start, unit_b_timer_rst, unit_b_adc_start;
	int fails = 0, checked = 0, trigs = 0, trigs_b = 0, t0;
	int hc [4];
	logic [3:0] cm [5] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'h2};
	logic [3:0] cp [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
	int ce [5] = '{1, 1, 1, 4, 16};
	logic [7:0] pc [5] = '{8'h6c, 8'hef, 8'hac, 8'h2e, 8'h2d};
	logic [3:0] po [5] = '{4'h0, 4'h0, 4'hc, 4'hc, 4'hc};
	logic [3:0] pm [5] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
	int pn [5][4] = '{'{32, 0, 0, 12}, '{32, 20, 0, 32}, '{12, 20, 0, 0}, '{20, 12, 0, 0},
		'{12, 20, 0, 0}};
	cpw_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_one_count, .timer_three_count,
		.unit_pin_a_in, .unit_pin_b_in, .unit_a_out, .unit_a_oe_n, .unit_a_timer_rst,
		.unit_a_adc_start, .unit_b_out, .unit_b_oe_n, .unit_b_timer_rst, .unit_b_adc_start);
	cpw_far_model u_far (.aclk, .aresetn, .run, .clr, .rst_a(unit_a_timer_rst),
		.rst_b(unit_b_timer_rst), .count_a(timer_one_count), .count_b(timer_three_count));
	always #4 aclk = ~aclk;
	always @(posedge aclk) if (unit_a_timer_rst && unit_a_adc_start) trigs <= trigs + 1;
	always @(posedge aclk) if (unit_b_timer_rst && unit_b_adc_start) trigs_b <= trigs_b + 1;
	// ==========
	// Tasks
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 100) begin
			fails++;
			$display("mismatch bus_answer expected 1 seen 0");
			conclude();
		end
	endtask
	task automatic wr(input logic [13:0] i, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (n == 1) s_axi_bready <= 1'h1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
		s_axi_bready <= 1'h0;
		tmo(n);
		cmp("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input logic [13:0] i, input logic [7:0] e, input logic [1:0] er,
		input string nm);
		int n;
		n = 0;
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (n == 1) s_axi_rready <= 1'h1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
		s_axi_rready <= 1'h0;
		tmo(n);
		cmp("rresp", er, s_axi_rresp);
		if (er == 2'h0) cmp(nm, {24'h00_0000, e}, s_axi_rdata);
	endtask
	task automatic tmr(input int c);
		clr <= 1'h1;
		@(posedge aclk);
		clr <= 1'h0;
		run <= 1'h1;
		repeat (c) @(posedge aclk);
		run <= 1'h0;
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			unit_pin_a_in <= 1'h1;
			repeat (8) @(posedge aclk);
			unit_pin_a_in <= 1'h0;
			repeat (8) @(posedge aclk);
		end
	endtask
	// ==========
	// Sequence
	initial begin
		repeat (60000) @(posedge aclk);
		fails++;
		$display("mismatch run_length expected end seen hang");
		conclude();
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		cmp("oe_a", 4'hf, unit_a_oe_n);
		rd(CA, 8'h00, 2'h0, "ctrl_a");
		rd(CB, 8'h00, 2'h0, "ctrl_b");
		rd(14'h0010, 8'h00, 2'h2, "unmapped");
		wr(14'h0010, 8'h55, 2'h2);
		wr(CB, 8'h01, 2'h0);
		s_axi_wstrb <= 4'h0;
		wr(CB, 8'h55, 2'h0);
		s_axi_wstrb <= 4'h1;
		rd(CB, 8'h01, 2'h0, "ctrl_b");
		cmp("oe_b", 4'hf, unit_b_oe_n);
		$display("test registers done");
		wr(CB + `CPW_SUB_LOW, 8'h10, 2'h0);
		wr(CB + `CPW_SUB_HIGH, 8'h00, 2'h0);
		wr(CB, 8'h08, 2'h0);
		tmr(40);
		cmp("pin_b", 4'h1, unit_b_out);
		cmp("oe_b_cmp", 4'he, unit_b_oe_n);
		wr(CB, 8'h0b, 2'h0);
		t0 = trigs_b;
		tmr(30);
		cmp("triggers_b", 1, trigs_b - t0);
		cmp("out_b_trig", 4'h0, unit_b_out);
		rd(FL, 8'h02, 2'h0, "flag_b");
		wr(CB, 8'h00, 2'h0);
		$display("test unit_b done");
		wr(CA + `CPW_SUB_LOW, 8'h40, 2'h0);
		wr(CA + `CPW_SUB_HIGH, 8'h00, 2'h0);
		foreach (cm[k]) begin
			wr(CA, 8'h00, 2'h0);
			wr(FL, 8'h03, 2'h0);
			wr(CA, {4'h0, cm[k]}, 2'h0);
			repeat (2) @(posedge aclk);
			p0 = unit_a_out[0];
			if (cm[k] > 4'h7 && cm[k] < 4'ha) cmp("pin_init", cm[k][0], p0);
			cmp("oe_cmp", cm[k] < 4'ha ? 4'he : 4'hf, unit_a_oe_n);
			t0 = trigs;
			tmr(80);
			if (cm[k] < 4'ha) cmp("pin_match", !p0, unit_a_out[0]);
			cmp("triggers", cm[k] == 4'hb, trigs - t0);
			rd(FL, 8'h01, 2'h0, "flag_cmp");
		end
		$display("test compare done");
		foreach (cp[k]) begin
			wr(CA, 8'h00, 2'h0);
			wr(FL, 8'h03, 2'h0);
			tmr(8'h20 + k);
			wr(CA, {4'h0, cp[k]}, 2'h0);
			pulses(ce[k] - 1);
			rd(FL, 8'h00, 2'h0, "flag_early");
			pulses(1);
			rd(FL, 8'h01, 2'h0, "flag_cap");
			rd(CA + `CPW_SUB_LOW, 8'h20 + k, 2'h0, "cap_low");
			rd(CA + `CPW_SUB_HIGH, 8'h00, 2'h0, "cap_high");
		end
		$display("test capture done");
		wr(CA + `CPW_SUB_PER, 8'h03, 2'h0);
		wr(CA + `CPW_SUB_LOW, 8'h01, 2'h0);
		wr(CA + `CPW_SUB_STEER, 8'h03, 2'h0);
		foreach (pc[k]) begin
			wr(CA, pc[k], 2'h0);
			repeat (40) @(posedge aclk);
			cmp("pwm_oe", po[k] & pm[k], unit_a_oe_n & pm[k]);
			hc = '{0, 0, 0, 0};
			repeat (32) begin
				@(posedge aclk);
				for (int j = 0; j < 4; j++) hc[j] += unit_a_out[j];
			end
			for (int j = 0; j < 4; j++) begin
				if (pm[k][j] && !po[k][j]) cmp("pwm_high", pn[k][j], hc[j]);
			end
		end
		wr(CA + `CPW_SUB_HIGH, 8'h77, 2'h0);
		rd(CA + `CPW_SUB_HIGH, 8'h01, 2'h0, "duty_buffer");
		$display("test pwm done");
		conclude();
	end
endmodule
`default_nettype wire
